// File: rtl/aicsel_clk_path.sv
// Clock path: source pick, invert, halve and glitch-free gate, all on pclk enables.
`timescale 1ns/1ps
module aicsel_clk_path
   import aicsel_pkg::*;
(
   input wire logic pclk, // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic [3:0] src_levels, // Sampled levels of ref A, ref B, loop A, loop B.
   input wire logic [1:0] src_pick, // Source select code.
   input wire logic invert, // Invert selected clock.
   input wire logic halve, // Divide by two.
   input wire logic gate_on, // Requested enable.
   output logic clk_out, // Gated output clock level.
   output logic running // Output clock is active.
);
   aicsel_state_t state_q, state_d;
   logic sel_q, half_q, out_q;
   logic sel_d, half_d;
   // Sources are taken as levels on pclk; a source not locked to the frame clock drops or repeats samples downstream.
   wire logic src_level = src_levels[src_pick] ^ invert; // R01 R02 R16
   wire logic rise = src_level & ~sel_q;
   wire logic path_level = halve ? half_q : sel_q; // R03
   wire logic path_next = halve ? (rise ? ~half_q : half_q) : src_level;
   wire logic at_low = ~path_level & ~path_next;
   assign sel_d = src_level;
   assign half_d = rise ? ~half_q : half_q;
   // Start and stop only while the path stays low so no phase is cut short.
   always_comb begin
      state_d = state_q;
      case (state_q)
         AICSEL_ST_OFF: if (gate_on && at_low) state_d = AICSEL_ST_RUN; // R04 R18
         AICSEL_ST_RUN: if (!gate_on) state_d = AICSEL_ST_STOP;
         AICSEL_ST_STOP: if (gate_on) state_d = AICSEL_ST_RUN;
            else if (at_low) state_d = AICSEL_ST_OFF; // R18
         default: state_d = AICSEL_ST_OFF;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= AICSEL_ST_OFF;
         sel_q <= 1'b0;
         half_q <= 1'b0;
         out_q <= 1'b0;
      end else begin
         state_q <= state_d;
         sel_q <= sel_d;
         half_q <= half_d;
         out_q <= (state_d != AICSEL_ST_OFF) ? path_next : 1'b0; // R04
      end
   end
   assign clk_out = out_q;
   assign running = (state_q != AICSEL_ST_OFF);

   property p_off_low;
      @(posedge pclk) disable iff (!presetn) (state_q == AICSEL_ST_OFF) |-> !out_q;
   endproperty
   a_off_low: assert property (p_off_low) else $error("Output clock high while gated off."); // R04
   property p_start_low;
      @(posedge pclk) disable iff (!presetn) $rose(running) |-> !out_q;
   endproperty
   a_start_low: assert property (p_start_low) else $error("Clock gate opened mid phase."); // R18
   property p_stop_low;
      @(posedge pclk) disable iff (!presetn) $fell(running) |-> !out_q && !$past(out_q);
   endproperty
   a_stop_low: assert property (p_stop_low) else $error("Clock gate closed mid phase."); // R18
   property p_halve;
      @(posedge pclk) disable iff (!presetn)
         (state_q == AICSEL_ST_RUN && $stable(src_pick) && $stable(invert) && halve && $past(halve)
         && (src_levels[src_pick] ^ invert) && !sel_q) |=> out_q != $past(out_q);
   endproperty
   a_halve: assert property (p_halve) else $error("Halved clock missed a toggle."); // R03
   property p_pass;
      @(posedge pclk) disable iff (!presetn)
         (state_q == AICSEL_ST_RUN && gate_on && !halve) |=> out_q == $past(src_levels[src_pick] ^ invert);
   endproperty
   a_pass: assert property (p_pass) else $error("Undivided clock not following source."); // R01 R02
   c_run: cover property (@(posedge pclk) disable iff (!presetn) $rose(running));
   c_halve: cover property (@(posedge pclk) disable iff (!presetn) running && halve && $rose(out_q));
   c_stop: cover property (@(posedge pclk) disable iff (!presetn) $fell(running));
endmodule // aicsel_clk_path

// File: rtl/aicsel_pkg.sv
// Package with register map, field positions and reset values for the port A clock selector.
// How it works
// R01: Two-bit field picks one of four clock sources.
// R02: Invert bit flips the selected clock.
// R03: Halve bit divides the selected clock by two.
// R04: Output clock runs only while gate bit set; here it runs on after the bit clears, until the path is next held low.
// R05: Software clears gate before changing the source.
// R06: Software enables a locked loop before selecting it.
// R07: Core clock taken from port A or B.
// R08: Software keeps core clock within frequency limits.
// R09: Software keeps port clocks within frequency limits.
// R10: Lower core clock minimum without oversampling flags.
// R11: Mixer bandwidth follows core clock source port rate.
// R12: Software picks active or fastest port as source.
// R13: Both pulls requested means neither pull enabled.
// R14: Maximum limit applies to the halved clock.
// R15: Software keeps slave port clock frame-synchronous.
// R16: Unsynchronised clock drops or repeats samples.
// R17: Mixed rates configure ratio for higher rate.
// R18: Gating never produces a shortened clock phase.
package aicsel_pkg;
   localparam logic [11:0] AICSEL_PORTA_SETUP_OFS = 12'h200;
   localparam logic [11:0] AICSEL_CORE_SETUP_OFS = 12'h208;
   localparam logic [11:0] AICSEL_PAD_SETUP_OFS = 12'h20c;
   localparam logic [11:0] AICSEL_STATUS_OFS = 12'h210;
   localparam int AICSEL_GATE_BIT = 0;
   localparam int AICSEL_HALVE_BIT = 1;
   localparam int AICSEL_INV_BIT = 2;
   localparam int AICSEL_SRC_LSB = 3;
   localparam logic [15:0] AICSEL_PORTA_SETUP_RST = 16'h0000;
   localparam logic [4:0] AICSEL_PORTA_SETUP_MASK = 5'h1f;
   localparam logic [3:0] AICSEL_PAD_SETUP_RST = 4'h0;
   localparam logic [1:0] AICSEL_SYNC_STAGES = 2'h2;
   typedef enum logic [1:0] {
      AICSEL_SRC_REF_A = 2'b00,
      AICSEL_SRC_REF_B = 2'b01,
      AICSEL_SRC_LOOP_A = 2'b10,
      AICSEL_SRC_LOOP_B = 2'b11
   } aicsel_src_t;
   typedef enum logic [1:0] {
      AICSEL_ST_OFF = 2'b00,
      AICSEL_ST_RUN = 2'b01,
      AICSEL_ST_STOP = 2'b10
   } aicsel_state_t;
endpackage

// File: rtl/aicsel_top.sv
// Port A clock selector with APB registers, core clock pick and pad pull control.
`timescale 1ns/1ps
module aicsel_top
   import aicsel_pkg::*;
(
   input wire logic pclk, // System clock, 100 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB write.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   input wire logic [3:0] pstrb, // APB byte strobes.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic ext_ref_clock_a, // Reference clock A level.
   input wire logic ext_ref_clock_b, // Reference clock B level.
   input wire logic locked_loop_a, // Locked loop A output level.
   input wire logic locked_loop_b, // Locked loop B output level.
   input wire logic port_b_master_clock, // Port B clock level.
   input wire logic [3:0] port_a_sample_rate, // Port A rate code.
   input wire logic [3:0] port_b_sample_rate, // Port B rate code.
   output logic port_a_master_clock, // Gated port A clock.
   output logic core_system_clock, // Core clock level.
   output logic [3:0] mixer_rate_code, // Rate code setting mixer bandwidth.
   output logic [1:0] ref_pullup_en, // Pull-up enables for ref A and B.
   output logic [1:0] ref_pulldown_en // Pull-down enables for ref A and B.
);
   logic [4:0] porta_q;
   logic core_src_q;
   logic [3:0] pad_q;
   logic core_q;
   logic [3:0] mix_q;
   logic running;
   logic a_clk;
   wire logic wr = psel & penable & pwrite;
   wire logic hit_porta = (paddr == AICSEL_PORTA_SETUP_OFS);
   wire logic hit_core = (paddr == AICSEL_CORE_SETUP_OFS);
   wire logic hit_pad = (paddr == AICSEL_PAD_SETUP_OFS);
   wire logic hit_stat = (paddr == AICSEL_STATUS_OFS);
   wire logic mapped = hit_porta | hit_core | hit_pad | hit_stat;
   wire logic port_a_clock_gate_on = porta_q[AICSEL_GATE_BIT];
   wire logic port_a_clock_halve = porta_q[AICSEL_HALVE_BIT];
   wire logic port_a_clock_invert = porta_q[AICSEL_INV_BIT];
   wire logic [1:0] port_a_clock_source_pick = porta_q[AICSEL_SRC_LSB +: 2];
   // Pulls: bits 1:0 pull-up, 3:2 pull-down; a pin asking for both gets neither.
   wire logic [1:0] both_pulls = pad_q[1:0] & pad_q[3:2];
   // Status is read-only and never refuses a write, so writes there are dropped quietly.
   wire logic [31:0] rd_mux = hit_porta ? {27'h0000000, porta_q} :
                              hit_core ? {31'h00000000, core_src_q} :
                              hit_pad ? {28'h0000000, pad_q} :
                              hit_stat ? {26'h0000000, running, core_q, mix_q} : 32'h00000000;

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign ref_pullup_en = pad_q[1:0] & ~both_pulls; // R13
   assign ref_pulldown_en = pad_q[3:2] & ~both_pulls; // R13
   assign port_a_master_clock = a_clk;
   assign core_system_clock = core_q;
   assign mixer_rate_code = mix_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         porta_q <= AICSEL_PORTA_SETUP_RST[4:0]; // R04
         core_src_q <= 1'b0;
         pad_q <= AICSEL_PAD_SETUP_RST;
      end else if (wr && pstrb[0]) begin
         if (hit_porta) porta_q <= pwdata[4:0] & AICSEL_PORTA_SETUP_MASK;
         if (hit_core) core_src_q <= pwdata[0];
         if (hit_pad) pad_q <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         core_q <= 1'b0;
         mix_q <= 4'h0;
      end else begin
         if (psel && !penable && !pwrite) prdata <= rd_mux;
         core_q <= core_src_q ? port_b_master_clock : a_clk; // R07
         mix_q <= core_src_q ? port_b_sample_rate : port_a_sample_rate; // R11
      end
   end

   aicsel_clk_path u_path (
      .pclk(pclk),
      .presetn(presetn),
      .src_levels({locked_loop_b, locked_loop_a, ext_ref_clock_b, ext_ref_clock_a}),
      .src_pick(port_a_clock_source_pick),
      .invert(port_a_clock_invert),
      .halve(port_a_clock_halve),
      .gate_on(port_a_clock_gate_on),
      .clk_out(a_clk),
      .running(running)
   );

   property p_core_b;
      @(posedge pclk) disable iff (!presetn) core_src_q && $stable(core_src_q) |=> core_q == $past(port_b_master_clock);
   endproperty
   a_core_b: assert property (p_core_b) else $error("Core clock not taken from port B."); // R07
   property p_mix;
      @(posedge pclk) disable iff (!presetn)
         !core_src_q |=> mix_q == $past(port_a_sample_rate);
   endproperty
   a_mix: assert property (p_mix) else $error("Mixer rate not from port A."); // R11
   property p_pulls;
      @(posedge pclk) disable iff (!presetn) (pad_q[0] && pad_q[2]) |-> !ref_pullup_en[0] && !ref_pulldown_en[0];
   endproperty
   a_pulls: assert property (p_pulls) else $error("Both pulls left on for ref A."); // R13
   c_core_b: cover property (@(posedge pclk) disable iff (!presetn) core_src_q && core_q);
endmodule // aicsel_top

// File: testbench/aicsel_src_model.sv
// Behavioural model of the reference clocks, the locked loops and the port B clock.
`timescale 1ns/1ps
module aicsel_src_model (
   input wire logic pclk, // Bench clock.
   input wire logic presetn, // Reset, active low.
   output logic [4:0] levels // Ref A, ref B, loop A, loop B, port B.
);
   // Periods of 6 to 14 pclk cycles keep every clock, halved or not, well below the pclk rate and within its rate limits.
   localparam int PER [5] = '{8, 10, 12, 6, 14};
   int cnt [5];
   // Every source runs from reset, so a loop is already locked before software can pick it.
   always_ff @(posedge pclk or negedge presetn) begin
      for (int i = 0; i < 5; i++) begin
         if (!presetn) cnt[i] <= 0;
         else cnt[i] <= (cnt[i] + 1) % PER[i];
      end
   end
   // Short high phases make inversion visible as a change of duty.
   always_comb for (int i = 0; i < 5; i++) levels[i] = (cnt[i] < 2);
endmodule // aicsel_src_model

// File: testbench/aicsel_tb_top.sv
// Self-checking bench for the port A clock selector.
`timescale 1ns/1ps
module aicsel_tb_top;
   import aicsel_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready, pa_clk, core_clk;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [3:0] rate_a = '0, rate_b = '0, mix;
   logic [4:0] lv;
   logic [1:0] pu, pd;
   logic [32:0] exp_q [$];
   int mismatches = 0, cmp_count = 0, hi, rs, r;
   int per [4] = '{8, 10, 12, 6};
   always #5 pclk = ~pclk;
   aicsel_src_model u_aicsel_src_model (.pclk(pclk), .presetn(presetn), .levels(lv));
   aicsel_top u_aicsel_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_ref_clock_a(lv[0]), .ext_ref_clock_b(lv[1]), .locked_loop_a(lv[2]), .locked_loop_b(lv[3]),
      .port_b_master_clock(lv[4]), .port_a_sample_rate(rate_a), .port_b_sample_rate(rate_b),
      .port_a_master_clock(pa_clk), .core_system_clock(core_clk), .mixer_rate_code(mix),
      .ref_pullup_en(pu), .ref_pulldown_en(pd));
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic near(input int got, input int exp);
      chk(33'(got > exp - 7 && got < exp + 7), 33'h1);
   endtask
   // Reads note the expected {pslverr, prdata}; the monitor below compares at the access edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) exp_q.push_back(e);
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      psel <= 0;
      penable <= 0;
      if (n >= 16) begin
         mismatches++;
         final_report();
      end
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) chk({pslverr, prdata}, exp_q.pop_front());
   end
   task automatic meas(input bit core);
      logic p, s;
      p = 0;
      hi = 0;
      rs = 0;
      repeat (240) begin
         @(posedge pclk);
         s = core ? core_clk : pa_clk;
         hi += int'(s);
         rs += int'(s && !p);
         p = s;
      end
   endtask
   initial begin
      void'($urandom(53));
      repeat (10) @(posedge pclk);
      presetn <= 1;
      apb(0, AICSEL_PORTA_SETUP_OFS, 0, 33'h0);
      meas(0);
      chk(33'(hi), 33'h0);
      r = $urandom;
      apb(1, AICSEL_PORTA_SETUP_OFS, 32'(r), 0);
      apb(0, AICSEL_PORTA_SETUP_OFS, 0, {1'b0, 27'h0, 5'(r)});
      apb(0, 12'h300, 0, {1'b1, 32'h0});
      $display("test registers done");
      for (int k = 0; k < 4; k++) begin
         for (int m = 0; m < 3; m++) begin
            apb(1, AICSEL_PORTA_SETUP_OFS, 32'({k[1:0], m == 1, m == 2, 1'b0}), 0);
            apb(1, AICSEL_PORTA_SETUP_OFS, 32'({k[1:0], m == 1, m == 2, 1'b1}), 0);
            repeat (20) @(posedge pclk);
            meas(0);
            if (m == 0) near(hi, 480 / per[k]);
            if (m == 1) near(hi, 240 - 480 / per[k]);
            if (m == 2) near(rs, 120 / per[k]);
         end
      end
      $display("test clock path done");
      meas(1);
      near(hi, 120);
      chk(33'(mix), 33'(rate_a));
      rate_a <= 4'($urandom);
      rate_b <= 4'($urandom);
      apb(1, AICSEL_CORE_SETUP_OFS, 32'h1, 0);
      repeat (20) @(posedge pclk);
      meas(1);
      near(hi, 480 / 14);
      chk(33'(mix), 33'(rate_b));
      apb(1, AICSEL_PORTA_SETUP_OFS, 0, 0);
      repeat (20) @(posedge pclk);
      meas(0);
      chk(33'(hi), 33'h0);
      $display("test core clock done");
      for (int v = 0; v < 16; v++) begin
         apb(1, AICSEL_PAD_SETUP_OFS, 32'(v), 0);
         @(posedge pclk);
         chk(33'({pu, pd}), 33'({v[1:0] & ~v[3:2], v[3:2] & ~v[1:0]}));
         chk(33'(pready), 33'h1);
      end
      $display("test pulls done");
      final_report();
   end
endmodule // aicsel_tb_top
